// file: verilog/dsl_top.sv
// two-channel serial line unit: rate taps, formats, vectors and register port
//
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/1ps
module dsl_top #(
	parameter int CLK_HZ = dsl_pkg::CLK_HZ
) (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	output logic o_irq,
	input wire logic i_rxd0,
	input wire logic i_rxd1,
	output logic o_txd0,
	output logic o_txd1,
	output logic [7:0] o_vec0,
	output logic [7:0] o_vec1,
	output logic o_ref_tick
);
	// ============================================================
	// elaboration checks and derived constants
	localparam longint REF_INC_L = (longint'(dsl_pkg::REF_HZ) << 32) / longint'(CLK_HZ);
	localparam logic [31:0] REF_INC = REF_INC_L[31:0];
	// the accumulator spaces ticks by the floor or the ceiling of the clock ratio
	localparam int GAP_MIN = CLK_HZ / dsl_pkg::REF_HZ;
	localparam int GAP_MAX = (CLK_HZ + dsl_pkg::REF_HZ - 1) / dsl_pkg::REF_HZ;

	if (CLK_HZ < 2 * dsl_pkg::REF_HZ) begin : g_bad_clk
		$error("clock too slow to derive the reference");
	end
	if (GAP_MAX > 250) begin : g_fast_clk
		$error("clock too fast for the reference spacing counter");
	end

	// ============================================================
	// state
	typedef struct packed {
		logic [1:0][dsl_pkg::CTRL_W-1:0] ctrl;
		logic [7:0] vcfg;
		logic [7:0] stat;
		logic [7:0] mask;
		logic [31:0] rdata;
		logic [32:0] ref_acc;
		logic ref_tick;
		logic [7:0] ref_gap;
		logic [dsl_pkg::DIV_W-1:0] div_cnt;
		logic [1:0][7:0] vec;
	} dsl_top_st_t;

	dsl_top_st_t st_ff;
	dsl_top_st_t nxt_st;

	logic [1:0] tick16;
	logic [1:0] tx_start;
	logic [1:0] tx_busy;
	logic [1:0] tx_done;
	logic [1:0] txd;
	logic [1:0] rxd;
	logic [1:0] rx_done;
	logic [1:0] rx_perr;
	logic [1:0] rx_ferr;
	logic [1:0][7:0] rx_data;
	logic [7:0] ev;

	assign rxd = {i_rxd1, i_rxd0};

	function automatic logic vbit(input logic [1:0] mode, input logic ch1);
		logic r;
		r = 1'b0;
		unique case (mode)
			dsl_pkg::VM_ZERO: r = 1'b0;
			dsl_pkg::VM_ONE: r = 1'b1;
			dsl_pkg::VM_CH0: r = !ch1;
			dsl_pkg::VM_CH1: r = ch1;
		endcase
		return r;
	endfunction

	// ============================================================
	// per-channel rate select and serial engines
	for (genvar c = 0; c < 2; c++) begin : g_ch
		logic [2:0] sel;
		logic [dsl_pkg::DIV_W-1:0] msk;
		assign sel = st_ff.ctrl[c][dsl_pkg::CF_SEL +: 3];
		assign msk = dsl_pkg::TAP_MASK[sel];
		// one tick feeds both directions of the channel
		assign tick16[c] = st_ff.ref_tick && ((st_ff.div_cnt & msk) == msk);

		dsl_tx u_tx (
			.i_clk(i_clk),
			.i_resetn(i_resetn),
			.i_tick16(tick16[c]),
			.i_start(tx_start[c]),
			.i_data(i_wdata[7:0]),
			.i_fmt8(st_ff.ctrl[c][dsl_pkg::CF_FMT8]),
			.i_two_stop(st_ff.ctrl[c][dsl_pkg::CF_STOP2]),
			.i_even(st_ff.ctrl[c][dsl_pkg::CF_EVEN]),
			.o_txd(txd[c]),
			.o_busy(tx_busy[c]),
			.o_done(tx_done[c])
		);

		dsl_rx u_rx (
			.i_clk(i_clk),
			.i_resetn(i_resetn),
			.i_tick16(tick16[c]),
			.i_rxd(rxd[c]),
			.i_fmt8(st_ff.ctrl[c][dsl_pkg::CF_FMT8]),
			.i_even(st_ff.ctrl[c][dsl_pkg::CF_EVEN]),
			.o_data(rx_data[c]),
			.o_done(rx_done[c]),
			.o_perr(rx_perr[c]),
			.o_ferr(rx_ferr[c])
		);

		assign ev[c*dsl_pkg::ST_STRIDE + dsl_pkg::ST_RX] = rx_done[c];
		assign ev[c*dsl_pkg::ST_STRIDE + dsl_pkg::ST_TX] = tx_done[c];
		assign ev[c*dsl_pkg::ST_STRIDE + dsl_pkg::ST_PAR] = rx_done[c] && rx_perr[c];
		assign ev[c*dsl_pkg::ST_STRIDE + dsl_pkg::ST_FRM] = rx_done[c] && rx_ferr[c];
	end

	// a write to a busy transmitter is dropped; software polls the line register
	assign tx_start[0] = i_wr && (i_addr == dsl_pkg::REG_TX0) && !tx_busy[0];
	assign tx_start[1] = i_wr && (i_addr == dsl_pkg::REG_TX1) && !tx_busy[1];

	// ============================================================
	// next state
	always_comb begin
		nxt_st = st_ff;
		// fractional accumulator stands in for the crystal: average rate is REF_HZ, less the truncation of REF_INC
		nxt_st.ref_acc = {1'b0, st_ff.ref_acc[31:0]} + {1'b0, REF_INC};
		nxt_st.ref_tick = st_ff.ref_acc[32];
		if (st_ff.ref_tick) begin
			nxt_st.div_cnt = st_ff.div_cnt + 13'h0001;
		end
		// cycles since the last reference tick; zero until the first, held at its top
		if (st_ff.ref_tick) begin
			nxt_st.ref_gap = 8'h01;
		end else if (st_ff.ref_gap != 8'h00 && st_ff.ref_gap != 8'hff) begin
			nxt_st.ref_gap = st_ff.ref_gap + 8'h01;
		end

		for (int c = 0; c < 2; c++) begin
			nxt_st.vec[c] = {vbit(st_ff.vcfg[dsl_pkg::VF_B67 +: 2], c[0]),
				vbit(st_ff.vcfg[dsl_pkg::VF_B67 +: 2], c[0]),
				vbit(st_ff.vcfg[dsl_pkg::VF_B5 +: 2], c[0]),
				vbit(st_ff.vcfg[dsl_pkg::VF_B4 +: 2], c[0]),
				vbit(st_ff.vcfg[dsl_pkg::VF_B3 +: 2], c[0]),
				3'h0};
		end

		if (i_wr) begin
			unique case (i_addr)
				dsl_pkg::REG_CTRL0: nxt_st.ctrl[0] = i_wdata[dsl_pkg::CTRL_W-1:0];
				dsl_pkg::REG_CTRL1: nxt_st.ctrl[1] = i_wdata[dsl_pkg::CTRL_W-1:0];
				dsl_pkg::REG_VEC: nxt_st.vcfg = i_wdata[7:0];
				dsl_pkg::REG_MASK: nxt_st.mask = i_wdata[7:0];
				default: begin
				end
			endcase
		end

		nxt_st.rdata = '0;
		if (i_rd) begin
			unique case (i_addr)
				dsl_pkg::REG_CTRL0: nxt_st.rdata = {26'h0, st_ff.ctrl[0]};
				dsl_pkg::REG_CTRL1: nxt_st.rdata = {26'h0, st_ff.ctrl[1]};
				dsl_pkg::REG_VEC: nxt_st.rdata = {24'h0, st_ff.vcfg};
				dsl_pkg::REG_RX0: nxt_st.rdata = {24'h0, rx_data[0]};
				dsl_pkg::REG_RX1: nxt_st.rdata = {24'h0, rx_data[1]};
				dsl_pkg::REG_STAT: nxt_st.rdata = {24'h0, st_ff.stat};
				dsl_pkg::REG_MASK: nxt_st.rdata = {24'h0, st_ff.mask};
				dsl_pkg::REG_LINE: nxt_st.rdata = {30'h0, tx_busy};
				default: nxt_st.rdata = '0;
			endcase
		end

		// read clears, but an event in the same cycle survives
		if (i_rd && (i_addr == dsl_pkg::REG_STAT)) begin
			nxt_st.stat = ev;
		end else begin
			nxt_st.stat = st_ff.stat | ev;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			st_ff <= '{ctrl: {dsl_pkg::CTRL1_RST, dsl_pkg::CTRL0_RST},
				vcfg: dsl_pkg::VEC_RST, stat: '0, mask: '0, rdata: '0,
				ref_acc: '0, ref_tick: 1'b0, ref_gap: '0, div_cnt: '0, vec: '0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ============================================================
	// outputs
	assign o_rdata = st_ff.rdata;
	assign o_irq = |(st_ff.stat & st_ff.mask);
	assign o_txd0 = txd[0];
	assign o_txd1 = txd[1];
	assign o_vec0 = st_ff.vec[0];
	assign o_vec1 = st_ff.vec[1];
	assign o_ref_tick = st_ff.ref_tick;

	// ============================================================
	// checks
	AST_RDATA_SLOT: assert property (@(posedge i_clk) disable iff (!i_resetn)
		!$past(i_rd) |-> o_rdata == 32'h0)
		else $error("read data outside its slot");
	AST_STAT_CLEAR: assert property (@(posedge i_clk) disable iff (!i_resetn)
		i_rd && i_addr == dsl_pkg::REG_STAT && ev == 8'h0 |=> st_ff.stat == 8'h0)
		else $error("status not cleared by read");
	AST_STAT_SET: assert property (@(posedge i_clk) disable iff (!i_resetn)
		ev != 8'h0 |=> (st_ff.stat & $past(ev)) == $past(ev))
		else $error("event lost from status");
	AST_REF_GAP: assert property (@(posedge i_clk) disable iff (!i_resetn)
		o_ref_tick |-> ##[GAP_MIN:GAP_MAX] o_ref_tick)
		else $error("reference tick spacing wrong");
	AST_REF_QUIET: assert property (@(posedge i_clk) disable iff (!i_resetn)
		o_ref_tick && st_ff.ref_gap != 8'h00 |-> 32'(st_ff.ref_gap) >= GAP_MIN)
		else $error("reference tick too frequent");
	AST_CTRL_WR: assert property (@(posedge i_clk) disable iff (!i_resetn)
		i_wr && i_addr == dsl_pkg::REG_CTRL1
		|=> st_ff.ctrl[1] == $past(i_wdata[dsl_pkg::CTRL_W-1:0]))
		else $error("channel 1 control write lost");
	AST_TICK_ON_REF: assert property (@(posedge i_clk) disable iff (!i_resetn)
		tick16[0] && st_ff.ctrl[0][dsl_pkg::CF_SEL +: 3] == 3'h7 |-> st_ff.div_cnt[4:0] == 5'h1f)
		else $error("38400 tap off its divide point");
	AST_VEC_CONST: assert property (@(posedge i_clk) disable iff (!i_resetn)
		st_ff.vcfg[dsl_pkg::VF_B3 +: 2] == dsl_pkg::VM_ONE && $stable(st_ff.vcfg)
		|=> o_vec0[3] && o_vec1[3])
		else $error("constant vector bit not high on both");
	AST_VEC_OPP: assert property (@(posedge i_clk) disable iff (!i_resetn)
		st_ff.vcfg[dsl_pkg::VF_B67 +: 2] == dsl_pkg::VM_CH0 && $stable(st_ff.vcfg)
		|=> o_vec0[7:6] == 2'b11 && o_vec1[7:6] == 2'b00)
		else $error("channel vector bits not opposite");
	COV_IRQ: cover property (@(posedge i_clk) disable iff (!i_resetn) $rose(o_irq));
	COV_BOTH_TX: cover property (@(posedge i_clk) disable iff (!i_resetn) &tx_busy);
endmodule // dsl_top

// file: inc/dsl_pkg.sv
// constants and field layouts for the dual serial line configuration block
// ============================================================
package dsl_pkg;
	// ============================================================
	// timing
	localparam int CLK_HZ = 250_000_000;
	localparam int REF_HZ = 19_660_800;
	localparam int OVS = 16;
	localparam int MID = 8;
	localparam logic [3:0] OVS_LAST = 4'(OVS - 1);
	localparam logic [3:0] MID_LAST = 4'(MID - 1);
	localparam logic [3:0] FRAME_SHORT = 4'd10;
	localparam logic [3:0] FRAME_LONG = 4'd11;
	localparam int DIV_W = 13;
	// reference divide masks for sel 0..7: 150 .. 38400 baud at 16x
	localparam logic [DIV_W-1:0] TAP_MASK [8] = '{
		13'h1fff, 13'h0fff, 13'h03ff, 13'h01ff, 13'h00ff, 13'h007f, 13'h003f, 13'h001f};
	// ============================================================
	// register offsets
	localparam logic [7:0] REG_CTRL0 = 8'h00;
	localparam logic [7:0] REG_CTRL1 = 8'h04;
	localparam logic [7:0] REG_VEC = 8'h08;
	localparam logic [7:0] REG_TX0 = 8'h0c;
	localparam logic [7:0] REG_TX1 = 8'h10;
	localparam logic [7:0] REG_RX0 = 8'h14;
	localparam logic [7:0] REG_RX1 = 8'h18;
	localparam logic [7:0] REG_STAT = 8'h1c;
	localparam logic [7:0] REG_MASK = 8'h20;
	localparam logic [7:0] REG_LINE = 8'h24;
	// ctrl fields
	localparam int CF_SEL = 0;
	localparam int CF_FMT8 = 3;
	localparam int CF_STOP2 = 4;
	localparam int CF_EVEN = 5;
	localparam int CTRL_W = 6;
	localparam logic [CTRL_W-1:0] CTRL0_RST = 6'h0f;
	localparam logic [CTRL_W-1:0] CTRL1_RST = 6'h0d;
	// vector config: 2-bit mode per field, bit3, bit4, bit5, bits6-7
	localparam logic [1:0] VM_ZERO = 2'h0;
	localparam logic [1:0] VM_ONE = 2'h1;
	localparam logic [1:0] VM_CH0 = 2'h2;
	localparam logic [1:0] VM_CH1 = 2'h3;
	localparam int VF_B3 = 0;
	localparam int VF_B4 = 2;
	localparam int VF_B5 = 4;
	localparam int VF_B67 = 6;
	localparam logic [7:0] VEC_RST = 8'hbc;
	// status bits, per channel stride
	localparam int ST_RX = 0;
	localparam int ST_TX = 1;
	localparam int ST_PAR = 2;
	localparam int ST_FRM = 3;
	localparam int ST_STRIDE = 4;
endpackage

// file: verilog/dsl_tx.sv
// serial transmitter driven by a 16x tick enable
`timescale 1ns/1ps
module dsl_tx (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_tick16,
	input wire logic i_start,
	input wire logic [7:0] i_data,
	input wire logic i_fmt8,
	input wire logic i_two_stop,
	input wire logic i_even,
	output logic o_txd,
	output logic o_busy,
	output logic o_done
);
	typedef enum logic {DSL_TX_IDLE, DSL_TX_SHIFT} dsl_tx_state_t;
	typedef struct packed {
		dsl_tx_state_t state;
		logic [10:0] shreg;
		logic [3:0] nbits;
		logic [3:0] sub;
		logic txd;
		logic done;
	} dsl_tx_st_t;
	dsl_tx_st_t st_ff;
	dsl_tx_st_t nxt_st;
	logic par;

	always_comb begin
		nxt_st = st_ff;
		nxt_st.done = 1'b0;
		par = (^i_data[6:0]) ^ ~i_even;
		unique case (st_ff.state)
			DSL_TX_IDLE: begin
				if (i_start) begin
					nxt_st.state = DSL_TX_SHIFT;
					// format latched here so a mid-frame change cannot tear a character
					nxt_st.shreg = {2'b11, (i_fmt8 ? i_data : {par, i_data[6:0]}), 1'b0};
					nxt_st.nbits = i_two_stop ? dsl_pkg::FRAME_LONG : dsl_pkg::FRAME_SHORT;
					nxt_st.sub = '0;
					nxt_st.txd = 1'b0;
				end
			end
			DSL_TX_SHIFT: begin
				if (i_tick16) begin
					nxt_st.sub = st_ff.sub + 4'h1;
					if (st_ff.sub == dsl_pkg::OVS_LAST) begin
						nxt_st.shreg = {1'b1, st_ff.shreg[10:1]};
						nxt_st.nbits = st_ff.nbits - 4'h1;
						nxt_st.txd = st_ff.shreg[1];
						if (st_ff.nbits == 4'h1) begin
							nxt_st.state = DSL_TX_IDLE;
							nxt_st.txd = 1'b1;
							nxt_st.done = 1'b1;
						end
					end
				end
			end
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			st_ff <= '{state: DSL_TX_IDLE, shreg: '1, nbits: '0, sub: '0, txd: 1'b1, done: 1'b0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign o_txd = st_ff.txd;
	assign o_busy = (st_ff.state == DSL_TX_SHIFT);
	assign o_done = st_ff.done;

	AST_TX_START: assert property (@(posedge i_clk) disable iff (!i_resetn)
		i_start && !o_busy |=> !o_txd && o_busy)
		else $error("start bit not driven after start");
	AST_TX_BITLEN: assert property (@(posedge i_clk) disable iff (!i_resetn)
		$changed(o_txd) && $past(o_busy) |-> $past(i_tick16 && st_ff.sub == dsl_pkg::OVS_LAST))
		else $error("line changed off a 16-tick boundary");
	AST_TX_STOP: assert property (@(posedge i_clk) disable iff (!i_resetn)
		o_done |-> o_txd && !o_busy && $past(o_txd))
		else $error("frame ended without stop level");
	COV_TX_DONE: cover property (@(posedge i_clk) disable iff (!i_resetn) o_done);
endmodule // dsl_tx

// file: verilog/dsl_rx.sv
// serial receiver sampling bit centres on a 16x tick enable
`timescale 1ns/1ps
module dsl_rx (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_tick16,
	input wire logic i_rxd,
	input wire logic i_fmt8,
	input wire logic i_even,
	output logic [7:0] o_data,
	output logic o_done,
	output logic o_perr,
	output logic o_ferr
);
	typedef enum logic [1:0] {DSL_RX_IDLE, DSL_RX_START, DSL_RX_DATA, DSL_RX_STOP} dsl_rx_state_t;
	typedef struct packed {
		dsl_rx_state_t state;
		logic prev;
		logic [3:0] sub;
		logic [2:0] cnt;
		logic [7:0] shreg;
		logic [7:0] data;
		logic done;
		logic perr;
		logic ferr;
	} dsl_rx_st_t;
	dsl_rx_st_t st_ff;
	dsl_rx_st_t nxt_st;

	always_comb begin
		nxt_st = st_ff;
		nxt_st.done = 1'b0;
		nxt_st.prev = i_rxd;
		unique case (st_ff.state)
			DSL_RX_IDLE: begin
				if (st_ff.prev && !i_rxd) begin
					nxt_st.state = DSL_RX_START;
					nxt_st.sub = '0;
				end
			end
			DSL_RX_START: begin
				if (i_tick16) begin
					nxt_st.sub = st_ff.sub + 4'h1;
					if (st_ff.sub == dsl_pkg::MID_LAST) begin
						// a glitch shorter than half a bit is dropped here
						nxt_st.state = i_rxd ? DSL_RX_IDLE : DSL_RX_DATA;
						nxt_st.sub = '0;
						nxt_st.cnt = '0;
					end
				end
			end
			DSL_RX_DATA: begin
				if (i_tick16) begin
					nxt_st.sub = st_ff.sub + 4'h1;
					if (st_ff.sub == dsl_pkg::OVS_LAST) begin
						nxt_st.shreg = {i_rxd, st_ff.shreg[7:1]};
						nxt_st.cnt = st_ff.cnt + 3'h1;
						if (st_ff.cnt == 3'h7) begin
							nxt_st.state = DSL_RX_STOP;
						end
					end
				end
			end
			DSL_RX_STOP: begin
				if (i_tick16) begin
					nxt_st.sub = st_ff.sub + 4'h1;
					if (st_ff.sub == dsl_pkg::OVS_LAST) begin
						// only the first stop is checked; a second one reads as idle line
						nxt_st.state = DSL_RX_IDLE;
						nxt_st.done = 1'b1;
						nxt_st.ferr = !i_rxd;
						nxt_st.data = i_fmt8 ? st_ff.shreg : {1'b0, st_ff.shreg[6:0]};
						nxt_st.perr = !i_fmt8 && ((^st_ff.shreg) == i_even);
					end
				end
			end
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			st_ff <= '{state: DSL_RX_IDLE, prev: 1'b1, sub: '0, cnt: '0, shreg: '0,
				data: '0, done: 1'b0, perr: 1'b0, ferr: 1'b0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign o_data = st_ff.data;
	assign o_done = st_ff.done;
	assign o_perr = st_ff.perr;
	assign o_ferr = st_ff.ferr;

	AST_RX_MID: assert property (@(posedge i_clk) disable iff (!i_resetn)
		st_ff.state == DSL_RX_DATA && $past(st_ff.state) == DSL_RX_START
		|-> $past(i_tick16 && st_ff.sub == dsl_pkg::MID_LAST && !i_rxd))
		else $error("start bit not confirmed at its centre");
	AST_RX_FMT8: assert property (@(posedge i_clk) disable iff (!i_resetn)
		o_done && $past(i_fmt8) |-> !o_perr)
		else $error("parity error flagged in 8-bit format");
	AST_RX_7BIT: assert property (@(posedge i_clk) disable iff (!i_resetn)
		o_done && !$past(i_fmt8) |-> !o_data[7])
		else $error("parity bit leaked into 7-bit data");
	COV_RX_PERR: cover property (@(posedge i_clk) disable iff (!i_resetn) o_done && o_perr);
endmodule // dsl_rx

// file: tb/dsl_term.sv
// serial terminal model for the far end of one line
`timescale 1ns/1ps
module dsl_term (
	input wire logic i_clk,
	input wire logic i_line,
	output logic o_line
);
	logic [10:0] got;

	// the line idles at mark, so a released line reads high
	initial o_line = 1'b1;

	// ============================================================
	// send: lsb first, rate and format agreed with the channel
	task automatic send(input logic [10:0] fr, input int nb, input int bitc);
		for (int i = 0; i < nb; i++) begin
			o_line <= fr[i];
			repeat (bitc) @(posedge i_clk);
		end
		o_line <= 1'b1;
	endtask

	// ============================================================
	// receive: sample bit centres after the start edge
	task automatic grab(input int bitc, input int nb);
		int n;
		n = 0;
		got = '1;
		while (i_line === 1'b1 && n < 400000) begin
			@(posedge i_clk);
			#1;
			n++;
		end
		repeat (bitc / 2) @(posedge i_clk);
		// sampled 1 ns after the edge so the line has settled
		for (int i = 0; i < nb; i++) begin
			#1 got[i] = i_line;
			repeat (bitc) @(posedge i_clk);
		end
	endtask
endmodule // dsl_term

// file: tb/tb.sv
// self-checking bench for the dual serial line block
`timescale 1ns/1ps
module tb;
	// reference tick lands every second cycle, keeping frames short
	localparam int CLK = 39_321_600;
	logic i_clk;
	logic i_resetn;
	logic [7:0] i_addr;
	logic [31:0] i_wdata;
	logic i_wr;
	logic i_rd;
	logic [31:0] o_rdata;
	logic o_irq;
	logic rxd0;
	logic rxd1;
	logic o_txd0;
	logic o_txd1;
	logic [7:0] o_vec0;
	logic [7:0] o_vec1;
	logic o_ref_tick;
	int miscompares = 0;
	int n_compared = 0;

	dsl_top #(.CLK_HZ(CLK)) dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq),
		.i_rxd0(rxd0), .i_rxd1(rxd1), .o_txd0(o_txd0), .o_txd1(o_txd1), .o_vec0(o_vec0),
		.o_vec1(o_vec1), .o_ref_tick(o_ref_tick));
	dsl_term t0 (.i_clk(i_clk), .i_line(o_txd0), .o_line(rxd0));
	dsl_term t1 (.i_clk(i_clk), .i_line(o_txd1), .o_line(rxd1));

	initial begin
		i_clk = 1'b0;
		forever #2 i_clk = ~i_clk;
	end

	// ============================================================
	// helpers
	task automatic close_out();
		if (miscompares == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
			miscompares++;
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 d = o_rdata;
	endtask

	function automatic logic [7:0] slot(input logic [5:0] c, input logic [7:0] d);
		if (c[dsl_pkg::CF_FMT8]) return d;
		return {c[dsl_pkg::CF_EVEN] ? ^d[6:0] : ~^d[6:0], d[6:0]};
	endfunction

	function automatic logic [7:0] exp_vec(input logic [7:0] cfg, input int ch);
		logic [3:0] b;
		for (int f = 0; f < 4; f++) begin
			b[f] = cfg[2*f+1] ? (cfg[2*f] ^ (ch == 0)) : cfg[2*f];
		end
		return {b[3], b[3], b[2], b[1], b[0], 3'b000};
	endfunction

	// ============================================================
	// scenarios
	task automatic reset_case();
		logic [7:0] ra [5] = '{8'h00, 8'h04, 8'h08, 8'h20, 8'h40};
		logic [31:0] re [5] = '{32'h0f, 32'h0d, 32'hbc, 32'h00, 32'h00};
		logic [31:0] v;
		for (int k = 0; k < 5; k++) begin
			rd(ra[k], v);
			chk(v, re[k]);
		end
		chk(32'(o_vec0), 32'(exp_vec(8'hbc, 0)));
		chk(32'(o_vec1), 32'(exp_vec(8'hbc, 1)));
	endtask

	task automatic ref_case();
		int n;
		n = 0;
		repeat (1000) begin
			@(posedge i_clk);
			#1;
			n += int'(o_ref_tick === 1'b1);
		end
		chk(32'(n >= 499 && n <= 501), 32'h1);
	endtask

	task automatic vec_case();
		logic [7:0] cfg [5] = '{8'h00, 8'h55, 8'haa, 8'hff, 8'h39};
		for (int k = 0; k < 5; k++) begin
			wr(dsl_pkg::REG_VEC, 32'(cfg[k]));
			repeat (2) @(posedge i_clk);
			#1;
			chk(32'(o_vec0), 32'(exp_vec(cfg[k], 0)));
			chk(32'(o_vec1), 32'(exp_vec(cfg[k], 1)));
		end
	endtask

	task automatic tx_case(input int ch, input logic [5:0] c, input logic [7:0] d,
		input int baud, input logic irq_on);
		logic [31:0] v;
		logic [10:0] fr;
		int bitc;
		int nb;
		int cyc;
		bitc = CLK / baud;
		nb = c[dsl_pkg::CF_STOP2] ? 11 : 10;
		fr = {2'b11, slot(c, d), 1'b0};
		cyc = 0;
		v = '1;
		wr(8'(ch * 4), 32'(c));
		wr(dsl_pkg::REG_MASK, 32'(irq_on) << (dsl_pkg::ST_TX + 4 * ch));
		fork
			if (ch == 0) t0.grab(bitc, nb); else t1.grab(bitc, nb);
			begin
				wr(dsl_pkg::REG_TX0 + 8'(ch * 4), 32'(d));
				while (v[ch] !== 1'b0 && cyc < 400000) begin
					rd(dsl_pkg::REG_LINE, v);
					cyc += 2;
				end
			end
		join
		// one tick of slack: the divider phase is free against the write
		chk(32'(cyc >= nb * bitc - bitc / 16 - 8 && cyc <= nb * bitc + bitc / 16 + 8), 1);
		chk(32'(ch ? t1.got : t0.got), 32'(fr));
		repeat (2) @(posedge i_clk);
		#1 chk(32'(o_irq), 32'(irq_on));
		rd(dsl_pkg::REG_STAT, v);
		chk(v, 32'h1 << (dsl_pkg::ST_TX + 4 * ch));
		@(posedge i_clk);
		#1 chk(32'(o_irq), 32'h0);
	endtask

	task automatic rx_case(input logic [5:0] c, input logic [7:0] d, input logic bad);
		logic [31:0] v;
		logic [10:0] fr;
		fr = {2'b11, slot(c, d) ^ {bad, 7'h00}, 1'b0};
		wr(dsl_pkg::REG_CTRL0, 32'(c));
		@(posedge i_clk);
		t0.send(fr, c[dsl_pkg::CF_STOP2] ? 11 : 10, CLK / 38400);
		rd(dsl_pkg::REG_RX0, v);
		chk(v, 32'(c[dsl_pkg::CF_FMT8] ? d : {1'b0, d[6:0]}));
		rd(dsl_pkg::REG_STAT, v);
		chk(v, 32'(1) | (32'(bad) << dsl_pkg::ST_PAR));
	endtask

	// channel 1 receive with the stop bit held low
	task automatic frm_case();
		logic [31:0] v;
		wr(dsl_pkg::REG_CTRL1, 32'h0f);
		wr(dsl_pkg::REG_MASK, 32'h1 << dsl_pkg::ST_STRIDE);
		@(posedge i_clk);
		t1.send({2'b10, 8'h5a, 1'b0}, 10, CLK / 38400);
		#1 chk(32'(o_irq), 32'h1);
		rd(dsl_pkg::REG_RX1, v);
		chk(v, 32'h5a);
		rd(dsl_pkg::REG_STAT, v);
		chk(v, (32'h1 << dsl_pkg::ST_STRIDE) | (32'h1 << (dsl_pkg::ST_STRIDE + dsl_pkg::ST_FRM)));
		#1 chk(32'(o_irq), 32'h0);
	endtask

	// ============================================================
	// main sequence and watchdog
	initial begin
		i_resetn = 1'b0;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_addr = 8'h00;
		i_wdata = 32'h0;
		repeat (10) @(posedge i_clk);
		i_resetn <= 1'b1;
		reset_case();
		ref_case();
		vec_case();
		tx_case(0, 6'h0f, 8'ha5, 38400, 1'b1);
		tx_case(0, 6'h17, 8'hd3, 38400, 1'b0);
		tx_case(1, 6'h27, 8'h35, 38400, 1'b1);
		tx_case(1, 6'h0e, 8'h81, 19200, 1'b0);
		rx_case(6'h0f, 8'h96, 1'b0);
		rx_case(6'h27, 8'h4b, 1'b0);
		rx_case(6'h07, 8'h2c, 1'b1);
		frm_case();
		close_out();
	end

	initial begin
		repeat (100000) @(posedge i_clk);
		miscompares++;
		close_out();
	end
endmodule // tb
